/* src/pmicei_pkg.sv */
package pmicei_pkg;

  // Clocking
  localparam int unsigned CLK_HZ = 25_000_000;
  localparam int unsigned TICK_HZ = 32_768;
  localparam int unsigned TICK_DIV = CLK_HZ / TICK_HZ;

  // Debounce times in microseconds, then in slow ticks (rounded up)
  localparam int unsigned DB_SHORT_US = 3_900;
  localparam int unsigned DB_BUTTON_US = 31_250;
  localparam int unsigned DB_FAULT_US = 8_000;
  localparam int unsigned DB_SHORT_TICKS = (DB_SHORT_US * TICK_HZ + 999_999) / 1_000_000;
  localparam int unsigned DB_BUTTON_TICKS = (DB_BUTTON_US * TICK_HZ + 999_999) / 1_000_000;
  localparam int unsigned DB_FAULT_TICKS = (DB_FAULT_US * TICK_HZ + 999_999) / 1_000_000;
  localparam int unsigned CNT_W = 14;

  // Register offsets
  localparam logic [7:0] OFS_STAT0 = 8'h05;
  localparam logic [7:0] OFS_MASK0 = 8'h06;
  localparam logic [7:0] OFS_SENSE0 = 8'h07;
  localparam logic [7:0] OFS_STAT1 = 8'h08;
  localparam logic [7:0] OFS_MASK1 = 8'h09;
  localparam logic [7:0] OFS_SENSE1 = 8'h0a;
  localparam logic [7:0] OFS_STAT3 = 8'h0e;
  localparam logic [7:0] OFS_MASK3 = 8'h0f;
  localparam logic [7:0] OFS_SENSE3 = 8'h10;
  localparam logic [7:0] OFS_DBNC = 8'h1b;

  // Implemented bit sets and reset values
  localparam logic [7:0] STAT0_BITS = 8'h3f;
  localparam logic [7:0] STAT1_BITS = 8'h3b;
  localparam logic [7:0] MASK1_BITS = 8'h7f;
  localparam logic [7:0] STAT3_BITS = 8'h80;
  localparam logic [7:0] STAT_RST = 8'h00;
  localparam logic [7:0] MASK0_RST = 8'h3f;
  localparam logic [7:0] MASK1_RST = 8'h7f;
  localparam logic [7:0] MASK3_RST = 8'h80;
  localparam logic [1:0] DBNC_RST = 2'h0;
  localparam int unsigned DBNC_POS = 0;

  // Channel numbering of the debounced sources
  localparam int unsigned NCH = 12;
  localparam int unsigned CH_BUTTON = 0;
  localparam int unsigned CH_LOWV = 1;
  localparam int unsigned CH_THERM = 2;
  localparam int unsigned CH_BUCK = 6;
  localparam int unsigned CH_FUSE = 11;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } pmicei_req_t;

endpackage : pmicei_pkg

/* src/pmicei_debounce.sv */
`timescale 1ns/1ns
`default_nettype none
module pmicei_debounce #(
  parameter int unsigned CNT_W = 14
) (
  input wire logic clk_i, // Core clock
  input wire logic srst_i, // Sync reset, high
  input wire logic tick_i, // Slow tick pulse
  input wire logic level_i, // Synchronised raw level
  input wire logic [CNT_W-1:0] rise_cnt_i, // Ticks for rising edge
  input wire logic [CNT_W-1:0] fall_cnt_i, // Ticks for falling edge
  output logic stable_o, // Debounced level
  output logic rose_o, // Debounced rise pulse
  output logic fell_o // Debounced fall pulse
);
  logic stable_q;
  logic rose_q;
  logic fell_q;
  logic [CNT_W-1:0] cnt_q;
  logic [CNT_W-1:0] cnt_inc;
  logic [CNT_W-1:0] period;
  logic differ;
  logic done;

  if (CNT_W < 2 || CNT_W > 31) begin : g_bad_w
    $error("CNT_W out of range");
  end

  assign differ = level_i != stable_q;
  assign period = level_i ? rise_cnt_i : fall_cnt_i;
  assign cnt_inc = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
  assign done = differ && tick_i && (cnt_inc >= period);

  // Any bounce back to the stable level restarts the period
  always_ff @(posedge clk_i) begin
    if (srst_i || !differ || done) begin
      cnt_q <= '0;
    end else if (tick_i) begin
      cnt_q <= cnt_inc;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stable_q <= 1'b0;
      rose_q <= 1'b0;
      fell_q <= 1'b0;
    end else begin
      stable_q <= done ? level_i : stable_q;
      rose_q <= done && level_i;
      fell_q <= done && !level_i;
    end
  end

  assign stable_o = stable_q;
  assign rose_o = rose_q;
  assign fell_o = fell_q;
endmodule : pmicei_debounce
`default_nettype wire

/* src/pmicei_top.sv */
// Overview of operation
// - Each event source owns a latched status bit, a mask bit and a live sense bit; the programming-supply pin has only a sense bit.
// - Low-supply event on comparator high-to-low, debounced 3.9 ms; sense 1 below threshold.
// - Button event when button input falls, stable for 31.25 ms.
// - Button rise also debounced 31.25 ms; button sense reads 1 while input high.
// - Four temperature events fire on both crossings, 3.9 ms debounce; sense 1 above.
// - Regulator overcurrent events fire on rising limit detector, 8.0 ms debounce.
// - Fuse-memory error event fires on rising edge with 8.0 ms debounce.
// - Two-bit select lengthens falling debounce of button and low-supply events.
// - First status register: bits 0..5 latched, reset 0, cleared by writing 1.
// - First mask register: same six bits, each resets to 1 (masked).
// - Low-supply sense bit 1 reads 1 when supply at or below threshold.
// - Temperature sense bits 2..5 in order of the four thresholds.
// - First sense register bit 7 reports the programming-supply pin level.
// - Second status: buck faults at bits 0,1,3,4,5; bits 2 and 6 reserved.
// - Status bits stay latched until the host writes 1.
// - Interrupt low while any unmasked bit set; new event during clear keeps it low.
// - Masked bits still latch; unmasking a set bit drives the interrupt low.
// - Sense registers are read-only live levels, never latched or cleared.
`timescale 1ns/1ns
`default_nettype none
module pmicei_top #(
  parameter int unsigned TICK_DIV = pmicei_pkg::TICK_DIV
) (
  input wire logic clk_i, // 25 MHz core clock
  input wire logic srst_i, // Sync reset, high
  input wire pmicei_pkg::pmicei_req_t req_i, // Register access from serial slave
  output logic [7:0] rd_data_o, // Read data, one cycle after rd
  output logic irq_out_n_o, // Interrupt to host, low active
  input wire logic power_button_input_i, // Button pin, async
  input wire logic supply_ok_cmp_i, // High while supply above threshold, async
  input wire logic [3:0] temp_above_i, // Temperature comparators, async
  input wire logic [4:0] buck_over_i, // Buck current-limit detectors, async
  input wire logic fuse_error_i, // Fuse-memory ECC error, async
  input wire logic prog_supply_pin_i // Programming-supply level, async
);
  localparam int unsigned CW = pmicei_pkg::CNT_W;
  localparam int unsigned NS = pmicei_pkg::NCH + 1;

  if (TICK_DIV < 2 || TICK_DIV > 65535) begin : g_bad_div
    $error("TICK_DIV out of range");
  end

  // Two-flop synchronisers for all pins
  logic [NS-1:0] pins;
  logic [NS-1:0] meta_q;
  logic [NS-1:0] sync_q;
  assign pins = {prog_supply_pin_i, fuse_error_i, buck_over_i, temp_above_i, supply_ok_cmp_i,
                 power_button_input_i};
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      meta_q <= '0;
      sync_q <= '0;
    end else begin
      meta_q <= pins;
      sync_q <= meta_q;
    end
  end

  // Slow tick, nominally 32 kHz
  logic [15:0] div_q;
  logic tick_q;
  logic div_end;
  assign div_end = div_q == 16'(TICK_DIV - 1);
  always_ff @(posedge clk_i) begin
    if (srst_i || div_end) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 16'h0001;
    end
  end
  always_ff @(posedge clk_i) begin
    tick_q <= !srst_i && div_end;
  end

  // Registers
  logic [7:0] stat0_q;
  logic [7:0] stat1_q;
  logic [7:0] stat3_q;
  logic [7:0] mask0_q;
  logic [7:0] mask1_q;
  logic [7:0] mask3_q;
  logic [1:0] dbnc_q;
  logic [7:0] rd_data_q;
  logic irq_n_q;

  // Debounce periods per channel
  logic [CW-1:0] t_short;
  logic [CW-1:0] t_button;
  logic [CW-1:0] t_fault;
  logic [CW-1:0] ext_mul;
  logic [CW-1:0] rise_cnt [pmicei_pkg::NCH];
  logic [CW-1:0] fall_cnt [pmicei_pkg::NCH];
  logic [pmicei_pkg::NCH-1:0] rose;
  logic [pmicei_pkg::NCH-1:0] fell;
  logic [pmicei_pkg::NCH-1:0] chan_level;

  assign t_short = CW'(pmicei_pkg::DB_SHORT_TICKS);
  assign t_button = CW'(pmicei_pkg::DB_BUTTON_TICKS);
  assign t_fault = CW'(pmicei_pkg::DB_FAULT_TICKS);
  assign ext_mul = CW'(dbnc_q) + CW'(1);
  assign chan_level = sync_q[pmicei_pkg::NCH-1:0];

  genvar gi;
  for (gi = 0; gi < pmicei_pkg::NCH; gi++) begin : g_chan
    if (gi == pmicei_pkg::CH_BUTTON) begin : g_btn
      assign rise_cnt[gi] = t_button;
      assign fall_cnt[gi] = CW'(t_button * ext_mul);
    end else if (gi == pmicei_pkg::CH_LOWV) begin : g_lowv
      assign rise_cnt[gi] = t_short;
      assign fall_cnt[gi] = CW'(t_short * ext_mul);
    end else if (gi < pmicei_pkg::CH_BUCK) begin : g_therm
      assign rise_cnt[gi] = t_short;
      assign fall_cnt[gi] = t_short;
    end else begin : g_fault
      assign rise_cnt[gi] = t_fault;
      assign fall_cnt[gi] = t_fault;
    end
    pmicei_debounce #(
      .CNT_W(CW)
    ) u_db (
      .clk_i(clk_i),
      .srst_i(srst_i),
      .tick_i(tick_q),
      .level_i(chan_level[gi]),
      .rise_cnt_i(rise_cnt[gi]),
      .fall_cnt_i(fall_cnt[gi]),
      .stable_o(),
      .rose_o(rose[gi]),
      .fell_o(fell[gi])
    );
  end

  // Event sets per register
  logic [7:0] set0;
  logic [7:0] set1;
  logic [7:0] set3;
  logic [3:0] therm_ev;
  logic [4:0] buck_ev;
  assign therm_ev = rose[pmicei_pkg::CH_THERM +: 4] | fell[pmicei_pkg::CH_THERM +: 4];
  assign buck_ev = rose[pmicei_pkg::CH_BUCK +: 5];
  assign set0 = {2'b00, therm_ev, fell[pmicei_pkg::CH_LOWV], fell[pmicei_pkg::CH_BUTTON]};
  assign set1 = {2'b00, buck_ev[4:2], 1'b0, buck_ev[1:0]};
  assign set3 = {rose[pmicei_pkg::CH_FUSE], 7'h00};

  // Live sense values
  logic [7:0] sense0;
  logic [7:0] sense1;
  logic [7:0] sense3;
  logic [4:0] buck_live;
  assign buck_live = sync_q[pmicei_pkg::CH_BUCK +: 5];
  assign sense0 = {sync_q[pmicei_pkg::NCH], 1'b0, sync_q[pmicei_pkg::CH_THERM +: 4],
                   !sync_q[pmicei_pkg::CH_LOWV], sync_q[pmicei_pkg::CH_BUTTON]};
  assign sense1 = {2'b00, buck_live[4:2], 1'b0, buck_live[1:0]};
  assign sense3 = {sync_q[pmicei_pkg::CH_FUSE], 7'h00};

  // Address decode
  logic hit_stat0;
  logic hit_stat1;
  logic hit_stat3;
  logic hit_mask0;
  logic hit_mask1;
  logic hit_mask3;
  logic hit_dbnc;
  logic [7:0] clr0;
  logic [7:0] clr1;
  logic [7:0] clr3;
  assign hit_stat0 = req_i.wr && req_i.addr == pmicei_pkg::OFS_STAT0;
  assign hit_stat1 = req_i.wr && req_i.addr == pmicei_pkg::OFS_STAT1;
  assign hit_stat3 = req_i.wr && req_i.addr == pmicei_pkg::OFS_STAT3;
  assign hit_mask0 = req_i.wr && req_i.addr == pmicei_pkg::OFS_MASK0;
  assign hit_mask1 = req_i.wr && req_i.addr == pmicei_pkg::OFS_MASK1;
  assign hit_mask3 = req_i.wr && req_i.addr == pmicei_pkg::OFS_MASK3;
  assign hit_dbnc = req_i.wr && req_i.addr == pmicei_pkg::OFS_DBNC;
  assign clr0 = hit_stat0 ? req_i.wdata : 8'h00;
  assign clr1 = hit_stat1 ? req_i.wdata : 8'h00;
  assign clr3 = hit_stat3 ? req_i.wdata : 8'h00;

  // Latched status: set wins over a same-cycle clear
  logic [7:0] stat0_d;
  logic [7:0] stat1_d;
  logic [7:0] stat3_d;
  assign stat0_d = ((stat0_q & ~clr0) | set0) & pmicei_pkg::STAT0_BITS;
  assign stat1_d = ((stat1_q & ~clr1) | set1) & pmicei_pkg::STAT1_BITS;
  assign stat3_d = ((stat3_q & ~clr3) | set3) & pmicei_pkg::STAT3_BITS;

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      stat0_q <= pmicei_pkg::STAT_RST;
      stat1_q <= pmicei_pkg::STAT_RST;
      stat3_q <= pmicei_pkg::STAT_RST;
    end else begin
      stat0_q <= stat0_d;
      stat1_q <= stat1_d;
      stat3_q <= stat3_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      mask0_q <= pmicei_pkg::MASK0_RST;
      mask1_q <= pmicei_pkg::MASK1_RST;
      mask3_q <= pmicei_pkg::MASK3_RST;
      dbnc_q <= pmicei_pkg::DBNC_RST;
    end else begin
      mask0_q <= hit_mask0 ? (req_i.wdata & pmicei_pkg::STAT0_BITS) : mask0_q;
      mask1_q <= hit_mask1 ? (req_i.wdata & pmicei_pkg::MASK1_BITS) : mask1_q;
      mask3_q <= hit_mask3 ? (req_i.wdata & pmicei_pkg::STAT3_BITS) : mask3_q;
      dbnc_q <= hit_dbnc ? req_i.wdata[pmicei_pkg::DBNC_POS +: 2] : dbnc_q;
    end
  end

  // Interrupt line from the next status state, so a clear and a new event resolve together
  logic pending;
  assign pending = |((stat0_d & ~mask0_q) | (stat1_d & ~mask1_q) | (stat3_d & ~mask3_q));
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      irq_n_q <= 1'b1;
    end else begin
      irq_n_q <= !pending;
    end
  end

  // Read mux; sense registers only mirror live levels
  logic [7:0] rd_mux;
  assign rd_mux = (req_i.addr == pmicei_pkg::OFS_STAT0) ? stat0_q :
                  (req_i.addr == pmicei_pkg::OFS_MASK0) ? mask0_q :
                  (req_i.addr == pmicei_pkg::OFS_SENSE0) ? sense0 :
                  (req_i.addr == pmicei_pkg::OFS_STAT1) ? stat1_q :
                  (req_i.addr == pmicei_pkg::OFS_MASK1) ? mask1_q :
                  (req_i.addr == pmicei_pkg::OFS_SENSE1) ? sense1 :
                  (req_i.addr == pmicei_pkg::OFS_STAT3) ? stat3_q :
                  (req_i.addr == pmicei_pkg::OFS_MASK3) ? mask3_q :
                  (req_i.addr == pmicei_pkg::OFS_SENSE3) ? sense3 :
                  (req_i.addr == pmicei_pkg::OFS_DBNC) ? {6'h00, dbnc_q} : 8'h00;
  always_ff @(posedge clk_i) begin
    if (srst_i) begin
      rd_data_q <= 8'h00;
    end else if (req_i.rd) begin
      rd_data_q <= rd_mux;
    end
  end

  assign rd_data_o = rd_data_q;
  assign irq_out_n_o = irq_n_q;
endmodule : pmicei_top
`default_nettype wire

/* test/pmicei_top_sva.sv */
`timescale 1ns/1ns
`default_nettype none
module pmicei_top_sva #(
  parameter int unsigned TICK_DIV = 2
) (
  input wire logic clk_i, // Clock
  input wire logic srst_i, // Reset
  input wire pmicei_pkg::pmicei_req_t req_i, // Access
  input wire logic [7:0] rd_data_o, // Read data
  input wire logic irq_out_n_o, // Interrupt
  input wire logic power_button_input_i, // Button
  input wire logic supply_ok_cmp_i, // Supply
  input wire logic [3:0] temp_above_i, // Temperature
  input wire logic [4:0] buck_over_i, // Bucks
  input wire logic fuse_error_i, // Fuse
  input wire logic prog_supply_pin_i // Prog supply
);
  logic [3:0] pb_q;
  logic [3:0] ps_q;
  logic [3:0] sp_q;
  logic [3:0] fu_q;
  logic [15:0] th_q;
  logic [19:0] bo_q;
  wire rd_s0 = req_i.rd && req_i.addr == pmicei_pkg::OFS_SENSE0;
  wire rd_s1 = req_i.rd && req_i.addr == pmicei_pkg::OFS_SENSE1;
  wire rd_s3 = req_i.rd && req_i.addr == pmicei_pkg::OFS_SENSE3;
  wire th_still = th_q[15:12] == th_q[3:0] && th_q[11:8] == th_q[3:0] && th_q[7:4] == th_q[3:0];
  wire bo_still = bo_q[19:15] == bo_q[4:0] && bo_q[14:10] == bo_q[4:0] && bo_q[9:5] == bo_q[4:0];
  // Pin history, so sense is only judged on settled pins
  always_ff @(posedge clk_i) begin
    pb_q <= {pb_q[2:0], power_button_input_i};
    ps_q <= {ps_q[2:0], prog_supply_pin_i};
    sp_q <= {sp_q[2:0], supply_ok_cmp_i};
    fu_q <= {fu_q[2:0], fuse_error_i};
    th_q <= {th_q[11:0], temp_above_i};
    bo_q <= {bo_q[14:0], buck_over_i};
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (srst_i);
  chk_reset_idle: assert property ($past(srst_i) |-> irq_out_n_o && rd_data_o == 8'h00)
    else $error("outputs not idle after reset");
  chk_stat0_unused: assert property (req_i.rd && req_i.addr == pmicei_pkg::OFS_STAT0 |=> rd_data_o[7:6] == 2'h0)
    else $error("status0 unused bits set");
  chk_stat1_rsvd: assert property (req_i.rd && req_i.addr == pmicei_pkg::OFS_STAT1
    |=> {rd_data_o[7:6], rd_data_o[2]} == 3'h0)
    else $error("status1 reserved bits set");
  chk_fuse_only: assert property (req_i.rd && req_i.addr == pmicei_pkg::OFS_STAT3 |=> rd_data_o[6:0] == 7'h00)
    else $error("status3 low bits set");
  chk_button_sense: assert property (rd_s0 && (pb_q == 4'hf || pb_q == 4'h0)
    |=> rd_data_o[0] == $past(pb_q[0]))
    else $error("button sense wrong");
  chk_prog_sense: assert property (rd_s0 && (ps_q == 4'hf || ps_q == 4'h0)
    |=> rd_data_o[7:6] == {$past(ps_q[0]), 1'b0})
    else $error("prog supply sense wrong");
  chk_lowv_sense: assert property (rd_s0 && (sp_q == 4'hf || sp_q == 4'h0)
    |=> rd_data_o[1] == !$past(sp_q[0]))
    else $error("low supply sense wrong");
  chk_temp_sense: assert property (rd_s0 && th_still
    |=> rd_data_o[5:2] == $past(th_q[3:0]))
    else $error("temperature sense wrong");
  chk_buck_sense: assert property (rd_s1 && bo_still
    |=> {rd_data_o[5:3], rd_data_o[1:0]} == $past(bo_q[4:0]) && rd_data_o[2] == 1'b0)
    else $error("buck sense wrong");
  chk_fuse_sense: assert property (rd_s3 && (fu_q == 4'hf || fu_q == 4'h0)
    |=> rd_data_o == {$past(fu_q[0]), 7'h00})
    else $error("fuse sense wrong");
  chk_irq_rise_wr: assert property ($rose(irq_out_n_o) |-> $past(req_i.wr))
    else $error("interrupt released without write");
  chk_mask_rdback: assert property ((req_i.wr && req_i.addr == pmicei_pkg::OFS_MASK0)
    ##1 (req_i.rd && req_i.addr == pmicei_pkg::OFS_MASK0)
    |=> rd_data_o == ($past(req_i.wdata, 2) & 8'h3f))
    else $error("mask0 readback wrong");
endmodule : pmicei_top_sva
bind pmicei_top pmicei_top_sva #(.TICK_DIV(TICK_DIV)) i_sva (.clk_i(clk_i), .srst_i(srst_i), .req_i(req_i),
  .rd_data_o(rd_data_o), .irq_out_n_o(irq_out_n_o), .power_button_input_i(power_button_input_i),
  .supply_ok_cmp_i(supply_ok_cmp_i), .temp_above_i(temp_above_i), .buck_over_i(buck_over_i),
  .fuse_error_i(fuse_error_i), .prog_supply_pin_i(prog_supply_pin_i));
`default_nettype wire

/* test/pmicei_host.sv */
`timescale 1ns/1ns
`default_nettype none
module pmicei_host (
  input wire logic clk_i, // Clock
  output var pmicei_pkg::pmicei_req_t req_o // Access to device
);
  initial req_o = '0;
  // One access, held for exactly one taking edge
  task automatic acc(input logic w, input logic r, input logic [7:0] a, input logic [7:0] d);
    req_o = {w, r, a, d};
    @(posedge clk_i);
    #1;
  endtask : acc
endmodule : pmicei_host
`default_nettype wire

/* test/pmicei_top_tb.sv */
`timescale 1ns/1ns
`default_nettype none
module pmicei_top_tb;
  localparam int TD = 2;
  logic clk_i = 1'b0;
  logic srst_i = 1'b1;
  pmicei_pkg::pmicei_req_t req;
  logic [7:0] rd_data;
  logic irq_n;
  logic button = 1'b1;
  logic supply_ok = 1'b1;
  logic [3:0] temp = 4'h0;
  logic [4:0] buck = 5'h00;
  logic fuse = 1'b0;
  logic prog = 1'b1;
  int failures = 0;
  int checks_done = 0;
  int seed = 43;
  int j;
  int k;
  logic [8:0] exp_q[$];
  logic p1 = 1'b0;
  logic [7:0] tb_bit;
  logic [7:0] bk_bit;
  logic [7:0] ra[8] = '{8'h05, 8'h06, 8'h08, 8'h09, 8'h0e, 8'h0f, 8'h20, 8'h07};
  logic [7:0] rv[8] = '{8'h00, 8'h3f, 8'h00, 8'h7f, 8'h00, 8'h80, 8'h00, 8'h81};
  always #20 clk_i = ~clk_i;
  pmicei_host i_host (.clk_i(clk_i), .req_o(req));
  pmicei_top #(.TICK_DIV(TD)) i_dut (.clk_i(clk_i), .srst_i(srst_i), .req_i(req), .rd_data_o(rd_data),
    .irq_out_n_o(irq_n), .power_button_input_i(button), .supply_ok_cmp_i(supply_ok), .temp_above_i(temp),
    .buck_over_i(buck), .fuse_error_i(fuse), .prog_supply_pin_i(prog));
  task automatic cmp(input string what, input logic [8:0] e, input logic [8:0] s);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask : cmp
  // Expected {irq, data} noted when the read is issued
  task automatic rd(input logic [7:0] a, input logic [8:0] e);
    exp_q.push_back(e);
    i_host.acc(1'b0, 1'b1, a, 8'h00);
  endtask : rd
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_host.acc(1'b1, 1'b0, a, d);
  endtask : wr
  task automatic gap(input int n);
    i_host.acc(1'b0, 1'b0, 8'h00, 8'h00);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : gap
  task automatic wrap_up;
    if (failures == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : wrap_up
  // Read data stand from the edge after the read until the next read
  always @(posedge clk_i) begin
    p1 <= req.rd;
  end
  always @(negedge clk_i) if (p1 === 1'b1) cmp("irq_rd_data", exp_q.pop_front(), {irq_n, rd_data});
  initial begin
    #(40 * 20000);
    failures++;
    wrap_up();
  end
  initial begin
    repeat (4) @(posedge clk_i);
    #1;
    srst_i = 1'b0;
    foreach (ra[i]) rd(ra[i], {1'b1, rv[i]});
    gap(2);
    j = ($random(seed) & 32'h7fff_ffff) % 4;
    k = ($random(seed) & 32'h7fff_ffff) % 5;
    tb_bit = 8'h04 << j;
    temp = 4'h1 << j;
    gap(4);
    rd(8'h07, {1'b1, 8'h81 | tb_bit});
    gap(220);
    rd(8'h05, 9'h100);
    gap(60);
    rd(8'h05, {1'b1, tb_bit});
    wr(8'h06, 8'h3f & ~tb_bit);
    rd(8'h06, {1'b0, 8'h3f & ~tb_bit});
    temp = 4'h0;
    gap(300);
    rd(8'h05, {1'b0, tb_bit});
    wr(8'h05, 8'hff);
    wr(8'h07, 8'h00);
    rd(8'h05, 9'h100);
    rd(8'h07, 9'h181);
    wr(8'h06, 8'h3f);
    bk_bit = k < 2 ? 8'h01 << k : 8'h02 << k;
    buck = 5'h01 << k;
    gap(540);
    rd(8'h08, {1'b1, bk_bit});
    wr(8'h09, 8'h00);
    rd(8'h08, {1'b0, bk_bit});
    wr(8'h08, 8'hff);
    rd(8'h08, 9'h100);
    fuse = 1'b1;
    gap(540);
    rd(8'h0e, 9'h180);
    rd(8'h10, 9'h180);
    rd(8'h0a, {1'b1, bk_bit});
    wr(8'h0f, 8'h00);
    rd(8'h0e, 9'h080);
    wr(8'h0e, 8'h80);
    rd(8'h0e, 9'h100);
    wr(8'h1b, 8'h01);
    rd(8'h1b, 9'h101);
    supply_ok = 1'b0;
    gap(4);
    rd(8'h07, 9'h183);
    gap(300);
    rd(8'h05, 9'h100);
    gap(240);
    rd(8'h05, 9'h102);
    button = 1'b0;
    gap(4);
    rd(8'h07, 9'h182);
    gap(3900);
    rd(8'h05, 9'h102);
    gap(250);
    rd(8'h05, 9'h103);
    gap(4);
    wrap_up();
  end
endmodule : pmicei_top_tb
`default_nettype wire
